// *** bench/atxf_write_port_tb.sv ***
`timescale 1ns/1ps

module atxf_write_port_tb;
	import atxf_pkg::*;
	logic        ref_clk_i, sys_rst_i, narrow, odd, whole, nf_sel, act_lo, slot;
	logic        wclk, wen_n, soc, cv, cf, ci, space, ferr, perr, ovr;
	logic [15:0] wdat, cw, m;
	logic [1:0]  wpar;
	int          errors, checks_done, seed, nferr, nperr, novr;
	logic [15:0] q[$];

	initial ref_clk_i = 1'b0;
	always #20 ref_clk_i = ~ref_clk_i;
	assign m = narrow ? 16'h00ff : 16'hffff;

	atxf_writer_model wr (.ref_clk_i(ref_clk_i), .parity_odd_i(odd), .parity_whole_word_i(whole),
		.wclk_o(wclk), .wen_n_o(wen_n), .soc_o(soc), .data_o(wdat), .prty_o(wpar));

	atxf_write_port #(.STORE_WORDS(64), .STAGE_DEPTH(8)) dut (
		.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .tx_fifo_if_clock_i(wclk),
		.tx_write_enable_n_i(wen_n), .tx_cell_first_word_flag_i(soc), .tx_cell_word_bus_i(wdat),
		.tx_word_parity_i(wpar), .bus_width_select_i(narrow), .parity_odd_i(odd),
		.parity_whole_word_i(whole), .space_near_full_sel_i(nf_sel), .space_active_low_i(act_lo),
		.cell_slot_i(slot), .cell_word_o(cw), .cell_word_valid_o(cv), .cell_first_o(cf),
		.cell_idle_o(ci), .tx_cell_space_available_o(space), .first_word_error_o(ferr),
		.parity_error_o(perr), .write_overrun_o(ovr));

	// Pulses are counted at the falling edge, where they have settled.
	always @(negedge ref_clk_i) begin
		nferr += (ferr === 1'b1);
		nperr += (perr === 1'b1);
		novr += (ovr === 1'b1);
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string s);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, s, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Every fourth word is preceded by a disabled write carrying a stray flag.
	task automatic wr_cell(input int n, input int fp, input logic bad);
		logic [15:0] d;
		for (int i = 0; i < n; i++) begin
			if (i % 4 == 3)
				wr.put(16'($random(seed)), 1'b1, 1'b0, 1'b0);
			d = 16'($random(seed));
			q.push_back(d);
			wr.put(d, i == fp, 1'b1, bad && i == 0);
		end
		wr.rel();
	endtask

	task automatic slot_chk(input logic idle);
		int len;
		len = narrow ? 53 : 27;
		@(negedge ref_clk_i);
		slot = 1'b1;
		@(negedge ref_clk_i);
		slot = 1'b0;
		for (int i = 0; i < 4 && cv !== 1'b1; i++)
			@(negedge ref_clk_i);
		for (int i = 0; i < len; i++) begin
			chk(cv, 1'b1, "valid");
			chk(cf, i == 0, "first");
			chk(ci, idle, "idle");
			if (!idle)
				chk(cw & m, q.pop_front() & m, "word");
			else if (i == 0)
				chk(cw, IDLE_CELL_HDR, "idle hdr");
			else if (i == len - 1)
				chk(cw, IDLE_CELL_FILL, "idle fill");
			@(negedge ref_clk_i);
		end
		chk(cv, 1'b0, "cell end");
	endtask

	initial begin
		#400us;
		errors++;
		tally_and_finish();
	end

	initial begin
		{errors, checks_done, nferr, nperr, novr} = '0;
		seed = 93;
		narrow = 1'b0;
		odd = 1'($random(seed));
		whole = 1'($random(seed));
		nf_sel = 1'b1;
		act_lo = 1'b0;
		slot = 1'b0;
		sys_rst_i = 1'b1;
		repeat (10) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		slot_chk(1'b1);
		wr_cell(10, 0, 1'b0);
		slot_chk(1'b1);
		wr_cell(17, 99, 1'b0);
		slot_chk(1'b0);
		chk(16'(nferr + nperr), 16'h0000, "no errors");
		$display("test partial and whole cells done");
		wr_cell(27, 5, 1'b1);
		chk(16'(nferr), 16'h0001, "misplaced flag");
		chk(16'(nperr), 16'h0001, "bad parity");
		slot_chk(1'b0);
		$display("test flag and parity done");
		wr_cell(27, 0, 1'b0);
		wr_cell(27, 0, 1'b0);
		wr_cell(6, 0, 1'b0);
		wr.put(16'h0000, 1'b0, 1'b0, 1'b0);
		chk(space, 1'b0, "near full");
		slot_chk(1'b0);
		chk(space, 1'b0, "held between rises");
		wr.put(16'h0000, 1'b0, 1'b0, 1'b0);
		chk(space, 1'b1, "space again");
		wr_cell(21, 0, 1'b0);
		slot_chk(1'b0);
		slot_chk(1'b0);
		$display("test space flag done");
		narrow = 1'b1;
		act_lo = 1'b1;
		sys_rst_i = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		sys_rst_i = 1'b0;
		chk(space, 1'b0, "reset flag");
		repeat (4) @(negedge ref_clk_i);
		wr_cell(53, 0, 1'b0);
		chk(space, 1'b0, "inverted flag");
		slot_chk(1'b0);
		slot_chk(1'b1);
		chk(16'(novr), 16'h0000, "overrun");
		$display("test narrow bus done");
		tally_and_finish();
	end
endmodule // atxf_write_port_tb

// *** bench/atxf_writer_model.sv ***
`timescale 1ns/1ps

module atxf_writer_model
	import atxf_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        parity_odd_i,
	input  wire logic        parity_whole_word_i,
	output logic             wclk_o,
	output logic             wen_n_o,
	output logic             soc_o,
	output logic      [15:0] data_o,
	output logic      [1:0]  prty_o
);
	initial begin
		wclk_o = 1'b0;
		wen_n_o = 1'b1;
		soc_o = 1'b0;
		data_o = 16'h0000;
		prty_o = 2'h0;
	end

	// One word per 360 ns clock.
	task automatic put(input logic [15:0] d, input logic f, input logic en, input logic bad);
		logic [1:0] p;
		p = parity_whole_word_i ? {^d ^ parity_odd_i, 1'b0} :
			{^d[15:8] ^ parity_odd_i, ^d[7:0] ^ parity_odd_i};
		@(negedge ref_clk_i);
		data_o = d;
		wen_n_o = ~en;
		soc_o = f;
		prty_o = {p[1] ^ bad, p[0]};
		repeat (4) @(negedge ref_clk_i);
		wclk_o = 1'b1;
		repeat (4) @(negedge ref_clk_i);
		wclk_o = 1'b0;
	endtask

	// Released bus shows no stale word, and the clock stands still.
	task automatic rel();
		wen_n_o = 1'b1;
		soc_o = 1'b0;
		data_o = ~data_o;
		prty_o = ~prty_o;
	endtask
endmodule // atxf_writer_model

// *** common/atxf_pkg.sv ***
package atxf_pkg;

	// Highest writer clock rate the port is specified for, in MHz.
	localparam int TX_IF_CLK_MAX_MHZ = 52;
	localparam int REF_CLK_MHZ       = 25;

	localparam int WORD_W            = 16;
	localparam int CELL_OCTETS       = 53;
	localparam logic [5:0] CELL_LEN_WIDE   = 6'h1b;
	localparam logic [5:0] CELL_LEN_NARROW = 6'h35;
	localparam int NEAR_FULL_SLACK   = 4;

	localparam logic [15:0] IDLE_CELL_HDR  = 16'h0000;
	localparam logic [15:0] IDLE_CELL_FILL = 16'h6a6a;

	typedef enum logic [1:0] {
		ATXF_OUT_WAIT,
		ATXF_OUT_CELL,
		ATXF_OUT_IDLE
	} atxf_out_st_t;

	typedef struct packed {
		logic        clk;
		logic        wen_n;
		logic        soc;
		logic        narrow;
		logic [1:0]  prty;
		logic [15:0] data;
	} atxf_pins_t;

	typedef struct packed {
		logic        first;
		logic [15:0] word;
	} atxf_word_t;

	function automatic logic [5:0] atxf_cell_len(input logic narrow);
		return narrow ? CELL_LEN_NARROW : CELL_LEN_WIDE;
	endfunction

endpackage

// *** logic/atxf_write_port.sv ***
`timescale 1ns/1ps

module atxf_stage_fifo
	import atxf_pkg::*;
#(
	parameter int WIDTH = 17,
	parameter int DEPTH = 8
) (
	input  wire logic             ref_clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0]   cnt;
	} atxf_fifo_st_t;

	atxf_fifo_st_t    s_r;
	atxf_fifo_st_t    s_nxt;
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic             push;
	logic             pop;

	assign in_ready_o  = s_r.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = s_r.cnt != '0;
	assign out_data_o  = mem_r[s_r.rp];
	assign push        = in_valid_i & in_ready_o;
	assign pop         = out_valid_o & out_ready_i;

	// Pointers wrap naturally, so DEPTH must be a power of two.
	always_comb begin
		s_nxt = s_r;
		if (push) begin
			s_nxt.wp = s_r.wp + AW'(1);
		end
		if (pop) begin
			s_nxt.rp = s_r.rp + AW'(1);
		end
		s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem_r[s_r.wp] <= in_data_i;
		end
	end

endmodule // atxf_stage_fifo

// Overview of operation
// (R1) Writer clock stays at or below limit; the edge sampling needs it well below half of ref_clk.
// (R2) Inputs sampled only at writer clock rise.
// (R3) Space-available output changes only at rise.
// (R4) Low write enable stores the word.
// (R5) Only complete cells go to payload.
// (R6) No complete cell: send idle cell.
// (R7) Wide mode uses all sixteen data bits.
// (R8) Narrow mode keeps only low eight bits.
// (R9) Data valid only with write enable.
// (R10) Misplaced first-word flag is reported.
// (R11) Writer drives selectable odd/even parity.
// (R12) Space output tracks full or near-full.
module atxf_write_port
	import atxf_pkg::*;
#(
	parameter int STORE_WORDS = 128,
	parameter int STAGE_DEPTH = 8
) (
	input  wire logic        ref_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        tx_fifo_if_clock_i,
	input  wire logic        tx_write_enable_n_i,
	input  wire logic        tx_cell_first_word_flag_i,
	input  wire logic [15:0] tx_cell_word_bus_i,
	input  wire logic [1:0]  tx_word_parity_i,
	input  wire logic        bus_width_select_i,
	input  wire logic        parity_odd_i,
	input  wire logic        parity_whole_word_i,
	input  wire logic        space_near_full_sel_i,
	input  wire logic        space_active_low_i,
	input  wire logic        cell_slot_i,
	output logic      [15:0] cell_word_o,
	output logic             cell_word_valid_o,
	output logic             cell_first_o,
	output logic             cell_idle_o,
	output logic             tx_cell_space_available_o,
	output logic             first_word_error_o,
	output logic             parity_error_o,
	output logic             write_overrun_o
);
	localparam int SAW = $clog2(STORE_WORDS);
	localparam logic [SAW:0] STORE_FULL = (SAW+1)'(STORE_WORDS);
	localparam logic [SAW:0] STORE_NEAR = (SAW+1)'(STORE_WORDS - NEAR_FULL_SLACK);

	typedef struct packed {
		atxf_pins_t    s1;
		atxf_pins_t    s2;
		logic          clk_d;
		atxf_out_st_t  st;
		logic [SAW-1:0] wptr;
		logic [SAW-1:0] rptr;
		logic [SAW:0]  cnt;
		logic [SAW:0]  cells;
		logic [5:0]    in_pos;
		logic [5:0]    out_pos;
		logic [15:0]   out_word;
		logic          out_vld;
		logic          out_first;
		logic          out_idle;
		logic          space;
		logic          soc_err;
		logic          par_err;
		logic          overrun;
	} atxf_top_st_t;

	atxf_top_st_t s_r;
	atxf_top_st_t s_nxt;
	logic [15:0]  store_r [STORE_WORDS];
	atxf_pins_t   pins;
	atxf_word_t   f_in;
	atxf_word_t   f_out;
	logic         link_edge;
	logic         wr_now;
	logic         f_in_rdy;
	logic         f_out_vld;
	logic         f_out_rdy;
	logic         take;
	logic         pop;
	logic         cell_done;
	logic         cell_sent;
	logic         room;
	logic [5:0]   len;
	logic [1:0]   par_exp;

	assign pins = '{clk: tx_fifo_if_clock_i, wen_n: tx_write_enable_n_i, soc: tx_cell_first_word_flag_i,
		narrow: bus_width_select_i, prty: tx_word_parity_i, data: tx_cell_word_bus_i};

	// Edge found on the second sync stage; writer clock must stay well below half of ref_clk.
	// (R1) R2 edge sampling
	assign link_edge = s_r.s2.clk & ~s_r.clk_d;
	// (R4) R9 write qualify
	assign wr_now    = link_edge & ~s_r.s2.wen_n;
	// (R7) R8 word width
	assign f_in      = '{first: s_r.s2.soc, word: s_r.s2.narrow ? {8'h00, s_r.s2.data[7:0]} : s_r.s2.data};
	assign f_out_rdy = s_r.cnt != STORE_FULL;
	assign take      = f_out_vld & f_out_rdy;
	assign len       = atxf_cell_len(s_r.s2.narrow);
	assign par_exp   = parity_whole_word_i ? {^s_r.s2.data ^ parity_odd_i, 1'b0}
		: {^s_r.s2.data[15:8] ^ parity_odd_i, ^s_r.s2.data[7:0] ^ parity_odd_i};

	atxf_stage_fifo #(
		.WIDTH($bits(atxf_word_t)),
		.DEPTH(STAGE_DEPTH)
	) u_stage (
		.ref_clk_i  (ref_clk_i),
		.sys_rst_i  (sys_rst_i),
		.in_valid_i (wr_now),
		.in_ready_o (f_in_rdy),
		.in_data_i  (f_in),
		.out_valid_o(f_out_vld),
		.out_ready_i(f_out_rdy),
		.out_data_o (f_out)
	);

	always_comb begin
		s_nxt         = s_r;
		s_nxt.s1      = pins;
		s_nxt.s2      = s_r.s1;
		s_nxt.clk_d   = s_r.s2.clk;
		s_nxt.overrun = wr_now & ~f_in_rdy;
		s_nxt.par_err = wr_now & (s_r.s2.prty != par_exp);
		// (R10) first flag check
		s_nxt.soc_err = take & f_out.first & (s_r.in_pos != 6'h00);
		cell_done     = take & (s_r.in_pos == len - 6'h01);
		if (take) begin
			s_nxt.wptr   = s_r.wptr + SAW'(1);
			s_nxt.in_pos = cell_done ? 6'h00 : s_r.in_pos + 6'h01;
		end
		pop           = 1'b0;
		cell_sent     = 1'b0;
		s_nxt.out_vld = 1'b0;
		case (s_r.st)
			ATXF_OUT_WAIT: begin
				s_nxt.out_pos = 6'h00;
				// (R5) R6 slot decision
				if (cell_slot_i) begin
					s_nxt.st = (s_r.cells != '0) ? ATXF_OUT_CELL : ATXF_OUT_IDLE;
				end
			end
			ATXF_OUT_CELL, ATXF_OUT_IDLE: begin
				s_nxt.out_vld   = 1'b1;
				s_nxt.out_first = s_r.out_pos == 6'h00;
				s_nxt.out_idle  = s_r.st == ATXF_OUT_IDLE;
				s_nxt.out_pos   = s_r.out_pos + 6'h01;
				if (s_r.st == ATXF_OUT_CELL) begin
					pop            = 1'b1;
					s_nxt.out_word = store_r[s_r.rptr];
					s_nxt.rptr     = s_r.rptr + SAW'(1);
				end else begin
					s_nxt.out_word = (s_r.out_pos == 6'h00) ? IDLE_CELL_HDR : IDLE_CELL_FILL;
				end
				if (s_r.out_pos == len - 6'h01) begin
					s_nxt.st  = ATXF_OUT_WAIT;
					cell_sent = s_r.st == ATXF_OUT_CELL;
				end
			end
			default: begin
				s_nxt.st = ATXF_OUT_WAIT;
			end
		endcase
		s_nxt.cnt   = s_r.cnt + (SAW+1)'(take) - (SAW+1)'(pop);
		s_nxt.cells = s_r.cells + (SAW+1)'(cell_done) - (SAW+1)'(cell_sent);
		// Staging space counts too, so a writer that obeys the flag never overruns.
		room = f_in_rdy & (space_near_full_sel_i ? (s_r.cnt < STORE_NEAR) : (s_r.cnt != STORE_FULL));
		// (R3) R12 space flag
		if (link_edge) begin
			s_nxt.space = room ^ space_active_low_i;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (take) begin
			store_r[s_r.wptr] <= f_out.word;
		end
	end

	assign cell_word_o               = s_r.out_word;
	assign cell_word_valid_o         = s_r.out_vld;
	assign cell_first_o              = s_r.out_first;
	assign cell_idle_o               = s_r.out_idle;
	assign tx_cell_space_available_o = s_r.space;
	assign first_word_error_o        = s_r.soc_err;
	assign parity_error_o            = s_r.par_err;
	assign write_overrun_o           = s_r.overrun;

	property p_sample_edge;
		@(posedge ref_clk_i) disable iff (sys_rst_i) !link_edge |-> !wr_now;
	endproperty
	a_sample_edge: assert property (p_sample_edge) else $error("write taken off a clock edge"); // R2

	property p_write_low;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			link_edge && !s_r.s2.wen_n && f_in_rdy |=> s_r.cnt != '0 || $past(u_stage.s_r.cnt) != '0 || u_stage.s_r.cnt != '0;
	endproperty
	a_write_low: assert property (p_write_low) else $error("enabled write not stored"); // R4

	property p_enable_high;
		@(posedge ref_clk_i) disable iff (sys_rst_i) link_edge && s_r.s2.wen_n |-> !wr_now;
	endproperty
	a_enable_high: assert property (p_enable_high) else $error("write taken with enable high"); // R9

	property p_narrow;
		@(posedge ref_clk_i) disable iff (sys_rst_i) wr_now && s_r.s2.narrow |-> f_in.word[15:8] == 8'h00;
	endproperty
	a_narrow: assert property (p_narrow) else $error("upper byte kept in narrow mode"); // R8

	property p_full_cell;
		@(posedge ref_clk_i) disable iff (sys_rst_i) s_r.st == ATXF_OUT_CELL |-> s_r.cells != '0;
	endproperty
	a_full_cell: assert property (p_full_cell) else $error("cell sent before complete"); // R5

	property p_idle_fill;
		@(posedge ref_clk_i) disable iff (sys_rst_i) s_r.st == ATXF_OUT_WAIT && cell_slot_i && s_r.cells == '0
			|=> s_r.st == ATXF_OUT_IDLE ##1 cell_word_valid_o && cell_idle_o && cell_first_o;
	endproperty
	a_idle_fill: assert property (p_idle_fill) else $error("idle cell not sent"); // R6

	property p_space_edge;
		@(posedge ref_clk_i) disable iff (sys_rst_i) !$stable(tx_cell_space_available_o) |-> $past(link_edge);
	endproperty
	a_space_edge: assert property (p_space_edge) else $error("space flag moved off edge"); // R3

	property p_space_full;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			link_edge && !space_active_low_i
			&& (space_near_full_sel_i ? s_r.cnt >= STORE_NEAR : s_r.cnt == STORE_FULL)
			|=> !tx_cell_space_available_o;
	endproperty
	a_space_full: assert property (p_space_full) else $error("space flag high while full"); // R12

	property p_first_flag;
		@(posedge ref_clk_i) disable iff (sys_rst_i)
			take && f_out.first && s_r.in_pos != 6'h00 |=> first_word_error_o ##1 !first_word_error_o || take;
	endproperty
	a_first_flag: assert property (p_first_flag) else $error("misplaced first flag missed"); // R10

	property p_cov_write;
		@(posedge ref_clk_i) disable iff (sys_rst_i) wr_now && f_in_rdy;
	endproperty
	c_cov_write: cover property (p_cov_write);

	property p_cov_cell;
		@(posedge ref_clk_i) disable iff (sys_rst_i) cell_sent;
	endproperty
	c_cov_cell: cover property (p_cov_cell);

	property p_cov_idle;
		@(posedge ref_clk_i) disable iff (sys_rst_i) cell_word_valid_o && cell_idle_o && cell_first_o;
	endproperty
	c_cov_idle: cover property (p_cov_idle);

endmodule // atxf_write_port
